// ---- logic/bake_consts.svh ----
// Constants for the bus address keypad entry block
`ifndef BAKE_CONSTS_SVH
`define BAKE_CONSTS_SVH

`define BAKE_CLK_HZ 20000000
// Lamp flash cycle and key timing, in milliseconds
`define BAKE_FLASH_MS 1000
`define BAKE_HOLD_MS 500
`define BAKE_REPEAT_MS 100
`define BAKE_FAST_MS 2000
`define BAKE_FLASH_CYC (`BAKE_CLK_HZ / 1000 * `BAKE_FLASH_MS)
`define BAKE_HOLD_CYC (`BAKE_CLK_HZ / 1000 * `BAKE_HOLD_MS)
`define BAKE_REPEAT_CYC (`BAKE_CLK_HZ / 1000 * `BAKE_REPEAT_MS)
`define BAKE_FAST_CYC (`BAKE_CLK_HZ / 1000 * `BAKE_FAST_MS)

`define BAKE_ADDR_MIN 7'h00
`define BAKE_ADDR_MAX 7'h7f
`define BAKE_ADDR_FACTORY 7'h7e
`define BAKE_STEP_BIG 7'h08
`define BAKE_STEP_HI 7'h10

// Register byte offsets
`define BAKE_REG_CTRL 4'h0
`define BAKE_REG_STATUS 4'h4
`define BAKE_REG_DISP 4'h8
// Control fields
`define BAKE_CTRL_SIM_MENU 0
`define BAKE_CTRL_WHOLE 1
`define BAKE_CTRL_SIM_COMM 2
`define BAKE_CTRL_RESET 3'h0
// Status fields
`define BAKE_ST_EDIT_LSB 8
`define BAKE_ST_SIM_REL 16
`define BAKE_ST_STATE_LSB 24

`define BAKE_RESP_OKAY 2'h0
`define BAKE_RESP_SLVERR 2'h2

`endif

// ---- logic/bake_pkg.sv ----
// Types for the bus address keypad entry block
package bake_pkg;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR_ID = 8'h02,
        ST_SEL_LO = 8'h04,
        ST_SEL_HI = 8'h08,
        ST_EDIT_LO = 8'h10,
        ST_EDIT_HI = 8'h20,
        ST_EDIT_ALL = 8'h40,
        ST_SIM = 8'h80
    } bake_state_t;

    typedef struct packed {
        bake_state_t st;
        logic loaded;
        logic [6:0] active;
        logic [6:0] edit;
        logic sim_rel;
        logic sim_choice;
        logic [2:0] ctrl;
        logic up_q;
        logic dn_q;
        logic menu_q;
        logic both_q;
        logic [31:0] hold_cnt;
        logic [31:0] rep_cnt;
        logic [31:0] flash_cnt;
        logic [4:0] lamp;
        logic [15:0] pos_ret;
        logic nvm_wr;
        logic aw_got;
        logic [3:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bake_regs_t;

endpackage : bake_pkg

// ---- logic/bake_top.sv ----
// Bus address keypad entry and simulation release with AXI4-Lite registers
`timescale 1ns/1ps
`include "bake_consts.svh"

module bake_top #(
    parameter int unsigned FLASH_CYC = `BAKE_FLASH_CYC,
    parameter int unsigned HOLD_CYC = `BAKE_HOLD_CYC,
    parameter int unsigned REPEAT_CYC = `BAKE_REPEAT_CYC,
    parameter int unsigned FAST_CYC = `BAKE_FAST_CYC
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic key_up_i,
    input wire logic key_down_i,
    input wire logic key_menu_i,
    input wire logic [15:0] pos_meas_i,
    input wire logic [15:0] sim_val_i,
    input wire logic nvm_valid_i,
    input wire logic [7:0] nvm_data_i,
    output logic [4:0] lamp_o,
    output logic [6:0] bus_addr_o,
    output logic [15:0] pos_ret_o,
    output logic nvm_wr_o,
    output logic [7:0] nvm_data_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import bake_pkg::*;

    bake_regs_t r;
    bake_regs_t next_r;

    // Saturating step keeps the edit inside 0..127
    function automatic logic [6:0] bake_step(input logic [6:0] v, input logic [6:0] s,
                                             input logic up);
        logic [7:0] sum;
        sum = {1'b0, v} + {1'b0, s};
        if (up) begin
            bake_step = sum[7] ? `BAKE_ADDR_MAX : sum[6:0];
        end else begin
            bake_step = (v < s) ? `BAKE_ADDR_MIN : v - s;
        end
    endfunction : bake_step

    logic [6:0] addr_ones;
    logic [6:0] addr_tens;
    logic [6:0] addr_hund;
    logic [6:0] addr_rem;
    always_comb begin
        addr_hund = (r.active >= 7'd100) ? 7'h01 : 7'h00;
        addr_rem = (r.active >= 7'd100) ? r.active - 7'd100 : r.active;
        addr_tens = addr_rem / 7'd10;
        addr_ones = addr_rem - addr_tens * 7'd10;
    end

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    assign s_axi_awready = !r.aw_got && !r.bvalid;
    assign s_axi_wready = !r.w_got && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    always_comb begin
        logic up_ev;
        logic dn_ev;
        logic both;
        logic both_ev;
        logic menu_ev;
        logic held;
        logic rep_fire;
        logic step_fire;
        logic edit_st;
        logic [6:0] unit;
        logic ph_half;
        logic ph_short;
        logic ph_long;
        logic [3:0] wa;
        logic [3:0] ra;
        next_r = r;
        both = key_up_i && key_down_i;
        both_ev = both && !r.both_q;
        up_ev = key_up_i && !r.up_q && !key_down_i;
        dn_ev = key_down_i && !r.dn_q && !key_up_i;
        menu_ev = key_menu_i && !r.menu_q;
        held = key_up_i ^ key_down_i;
        next_r.up_q = key_up_i;
        next_r.dn_q = key_down_i;
        next_r.menu_q = key_menu_i;
        next_r.both_q = both;
        next_r.nvm_wr = 1'b0;
        edit_st = (r.st == ST_EDIT_LO) || (r.st == ST_EDIT_HI) || (r.st == ST_EDIT_ALL);

        // Hold timing for auto-repeat
        rep_fire = 1'b0;
        if (held && edit_st) begin
            if (r.hold_cnt < FAST_CYC) begin
                next_r.hold_cnt = r.hold_cnt + 32'h1;
            end
            if (r.hold_cnt >= HOLD_CYC) begin
                if (r.rep_cnt >= REPEAT_CYC - 1) begin
                    next_r.rep_cnt = 32'h0;
                    rep_fire = 1'b1;
                end else begin
                    next_r.rep_cnt = r.rep_cnt + 32'h1;
                end
            end
        end else begin
            next_r.hold_cnt = 32'h0;
            next_r.rep_cnt = 32'h0;
        end
        step_fire = up_ev || dn_ev || rep_fire;
        unit = 7'h01;
        if (r.st == ST_EDIT_HI) begin
            unit = `BAKE_STEP_HI;
        end else if (r.st == ST_EDIT_ALL && r.hold_cnt >= FAST_CYC) begin
            unit = `BAKE_STEP_BIG;
        end

        if (!r.loaded) begin
            // Restore after reset release; factory address when storage is blank
            next_r.loaded = 1'b1;
            next_r.active = nvm_valid_i ? nvm_data_i[6:0] : `BAKE_ADDR_FACTORY;
            next_r.sim_rel = nvm_valid_i && nvm_data_i[7];
        end else begin
            unique case (r.st)
                ST_IDLE: begin
                    if (menu_ev) begin
                        next_r.edit = r.active;
                        next_r.sim_choice = r.sim_rel;
                        next_r.st = r.ctrl[`BAKE_CTRL_SIM_MENU] ? ST_SIM : ST_ADDR_ID;
                    end
                end
                ST_ADDR_ID: begin
                    if (menu_ev) begin
                        next_r.st = r.ctrl[`BAKE_CTRL_WHOLE] ? ST_EDIT_ALL : ST_SEL_LO;
                    end
                end
                ST_SEL_LO: begin
                    if (up_ev || dn_ev) begin
                        next_r.st = ST_SEL_HI;
                    end else if (menu_ev) begin
                        next_r.st = ST_EDIT_LO;
                    end
                end
                ST_SEL_HI: begin
                    if (up_ev || dn_ev) begin
                        next_r.st = ST_SEL_LO;
                    end else if (menu_ev) begin
                        next_r.st = ST_EDIT_HI;
                    end
                end
                ST_EDIT_LO, ST_EDIT_HI, ST_EDIT_ALL: begin
                    if (both_ev) begin
                        next_r.active = r.edit;
                        next_r.nvm_wr = 1'b1;
                        next_r.st = ST_IDLE;
                    end else if (menu_ev) begin
                        next_r.st = ST_IDLE; // Abandon: active stays
                    end else if (step_fire) begin
                        next_r.edit = bake_step(r.edit, unit, key_up_i);
                    end
                end
                ST_SIM: begin
                    if (both_ev) begin
                        next_r.sim_rel = r.sim_choice;
                        next_r.nvm_wr = 1'b1;
                        next_r.st = ST_IDLE;
                    end else if (menu_ev) begin
                        next_r.st = ST_IDLE;
                    end else if (up_ev || dn_ev) begin
                        next_r.sim_choice = !r.sim_choice;
                    end
                end
            endcase
        end

        // Lamp flashing: bit 0 is the menu lamp, bits 1..4 are lamps one to four
        next_r.flash_cnt = (r.flash_cnt >= FLASH_CYC - 1) ? 32'h0 : r.flash_cnt + 32'h1;
        ph_half = r.flash_cnt < FLASH_CYC / 2;
        ph_short = r.flash_cnt < FLASH_CYC / 4;
        ph_long = r.flash_cnt < FLASH_CYC / 4 * 3;
        unique case (r.st)
            ST_IDLE: next_r.lamp = 5'h00;
            ST_ADDR_ID: next_r.lamp = {ph_half, ph_half, 1'b0, 1'b0, ph_half};
            ST_SEL_LO: next_r.lamp = {1'b0, 1'b0, 1'b0, ph_long, ph_short};
            ST_SEL_HI: next_r.lamp = {1'b0, 1'b0, ph_long, 1'b0, ph_short};
            ST_EDIT_LO: next_r.lamp = {r.edit[3:0], 1'b0};
            ST_EDIT_HI: next_r.lamp = {1'b0, r.edit[6:4], 1'b0};
            ST_EDIT_ALL: next_r.lamp = {r.edit[3:0], 1'b1};
            ST_SIM: next_r.lamp = {r.sim_choice, 2'h0, !r.sim_choice, 1'b0};
        endcase

        // Position returned to the control system
        next_r.pos_ret = (r.sim_rel && r.ctrl[`BAKE_CTRL_SIM_COMM]) ? sim_val_i
                                                                   : pos_meas_i;

        // AXI4-Lite write: address and data in either order
        if (aw_hs) begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = s_axi_awaddr[3:0];
        end
        if (w_hs) begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end
        wa = aw_hs ? s_axi_awaddr[3:0] : r.awaddr;
        if ((r.aw_got || aw_hs) && (r.w_got || w_hs)) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = `BAKE_RESP_OKAY;
            if (wa == `BAKE_REG_CTRL) begin
                if (w_hs ? s_axi_wstrb[0] : r.wstrb[0]) begin
                    next_r.ctrl = w_hs ? s_axi_wdata[2:0] : r.wdata[2:0];
                end
            end else if (wa != `BAKE_REG_STATUS && wa != `BAKE_REG_DISP) begin
                next_r.bresp = `BAKE_RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // AXI4-Lite read
        ra = s_axi_araddr[3:0];
        if (ar_hs) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = `BAKE_RESP_OKAY;
            next_r.rdata = 32'h0;
            if (ra == `BAKE_REG_CTRL) begin
                next_r.rdata[2:0] = r.ctrl;
            end else if (ra == `BAKE_REG_STATUS) begin
                next_r.rdata[6:0] = r.active;
                next_r.rdata[`BAKE_ST_EDIT_LSB +: 7] = r.edit;
                next_r.rdata[`BAKE_ST_SIM_REL] = r.sim_rel;
                next_r.rdata[`BAKE_ST_STATE_LSB +: 8] = r.st;
            end else if (ra == `BAKE_REG_DISP) begin
                next_r.rdata[3:0] = addr_ones[3:0];
                next_r.rdata[7:4] = addr_tens[3:0];
                next_r.rdata[11:8] = addr_hund[3:0];
                next_r.rdata[22:16] = r.active;
            end else begin
                next_r.rresp = `BAKE_RESP_SLVERR;
            end
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.active <= `BAKE_ADDR_FACTORY;
            r.ctrl <= `BAKE_CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign lamp_o = r.lamp;
    assign bus_addr_o = r.active;
    assign pos_ret_o = r.pos_ret;
    assign nvm_wr_o = r.nvm_wr;
    assign nvm_data_o = {r.sim_rel, r.active};
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

endmodule : bake_top

// ---- tb/bake_properties.sv ----
// Port checker for the bus address keypad entry block
`timescale 1ns/1ps
module bake_properties (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] pos_meas_i,
    input wire logic [6:0] bus_addr_o,
    input wire logic [15:0] pos_ret_o,
    input wire logic nvm_wr_o,
    input wire logic [7:0] nvm_data_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("write response missing");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped early");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    a_read_blocks: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read response not held");
    a_store_pulse: assert property (nvm_wr_o |=> !nvm_wr_o)
        else $error("store strobe longer than one cycle");
    // Depth two skips the restore edge that follows each reset release
    a_simrel_commit: assert property ($past(arst_n_i, 2) && $changed(nvm_data_o[7])
        |-> nvm_wr_o) else $error("simulation release moved without commit");
    a_addr_commit: assert property ($past(arst_n_i, 2) && $changed(bus_addr_o)
        |-> nvm_wr_o) else $error("active address moved without commit");
    a_real_pos: assert property ($past(arst_n_i) && !$past(nvm_data_o[7])
        |-> pos_ret_o == $past(pos_meas_i)) else $error("real position not returned");
endmodule : bake_properties

bind bake_top bake_properties u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .pos_meas_i(pos_meas_i), .bus_addr_o(bus_addr_o), .pos_ret_o(pos_ret_o),
    .nvm_wr_o(nvm_wr_o), .nvm_data_o(nvm_data_o), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- tb/bake_operator.sv ----
// Operator model holding a key pattern for a set number of cycles
`timescale 1ns/1ps
module bake_operator (
    input wire logic mclk_i,
    input wire logic go_i,
    input wire logic [2:0] keys_i,
    input wire logic [7:0] len_i,
    output logic key_up_o,
    output logic key_down_o,
    output logic key_menu_o,
    output logic busy_o
);
    logic [7:0] cnt = 8'h00;
    logic [2:0] held = 3'h0;
    // Both keys start on one edge, so a commit is never seen as two singles
    always @(posedge mclk_i) begin
        if (go_i) begin
            held <= keys_i;
            cnt <= len_i;
        end else if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
        end else begin
            held <= 3'h0;
            cnt <= 8'h00;
        end
    end
    assign {key_menu_o, key_down_o, key_up_o} = held;
    assign busy_o = cnt != 8'h00;
endmodule : bake_operator

// ---- tb/bake_test.sv ----
// Self-checking bench for the bus address keypad entry block
`timescale 1ns/1ps
module bake_test;
    logic mclk_i = 1'b0, arst_n_i = 1'b0, up, dn, menu, busy, go = 1'b0;
    logic [2:0] kc = 3'h0;
    logic [7:0] kl = 8'h00, nvm_data_o;
    logic [15:0] pos_meas_i = 16'h0000, sim_val_i = 16'h0000, pos_ret_o;
    logic [4:0] lamp_o;
    logic [6:0] bus_addr_o;
    logic nvm_wr_o, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic awr, wr_rdy, bv, arr, rv;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int miscompares = 0, check_count = 0, cycles = 0, stores = 0;
    logic nvm_valid = 1'b0;
    logic [7:0] nvm_data = 8'h00;
    logic [3:0] ws = 4'hf;

    always #25 mclk_i = ~mclk_i;

    bake_top #(.FLASH_CYC(16), .HOLD_CYC(8), .REPEAT_CYC(4), .FAST_CYC(32)) uut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .key_up_i(up), .key_down_i(dn),
        .key_menu_i(menu), .pos_meas_i(pos_meas_i), .sim_val_i(sim_val_i),
        .nvm_valid_i(nvm_valid), .nvm_data_i(nvm_data), .lamp_o(lamp_o), .bus_addr_o(bus_addr_o),
        .pos_ret_o(pos_ret_o), .nvm_wr_o(nvm_wr_o), .nvm_data_o(nvm_data_o),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rre));
    bake_operator op (.mclk_i(mclk_i), .go_i(go), .keys_i(kc), .len_i(kl),
        .key_up_o(up), .key_down_o(dn), .key_menu_o(menu), .busy_o(busy));

    task automatic wrap_up;
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    always @(posedge mclk_i) begin
        cycles++;
        if (nvm_wr_o === 1'b1)
            stores++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (aw || w) begin
            @(posedge mclk_i);
            if (awr === 1'b1)
                aw = 1'b0;
            if (wr_rdy === 1'b1)
                w = 1'b0;
            awv <= aw;
            wv <= w;
        end
        do @(posedge mclk_i); while (bv !== 1'b1);
        r = bresp;
        bre <= 1'b0;
        // One idle edge, so a following call never reassigns bready in this step
        @(posedge mclk_i);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge mclk_i); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge mclk_i); while (rv !== 1'b1);
        d = rdata;
        r = rresp;
        rre <= 1'b0;
        // One idle edge, so a following call never reassigns rready in this step
        @(posedge mclk_i);
    endtask : rd

    // Keys: bit0 up, bit1 down, bit2 menu
    task automatic press(input logic [2:0] k, input logic [7:0] len);
        kc <= k;
        kl <= len;
        go <= 1'b1;
        @(posedge mclk_i);
        go <= 1'b0;
        @(posedge mclk_i);
        while (busy)
            @(posedge mclk_i);
        repeat (2) @(posedge mclk_i);
    endtask : press

    // Lit cycles of one lamp over one flash period
    task automatic duty(input int b, input int exp);
        int n;
        n = 0;
        repeat (16) begin
            @(posedge mclk_i);
            n += lamp_o[b];
        end
        chk(n, exp);
    endtask : duty

    task automatic t_power_up;
        logic [31:0] d;
        logic [1:0] r;
        chk(bus_addr_o, 32'h7e);
        rd(32'h4, d, r);
        chk({d[31:24], 1'b0, d[6:0]}, 32'h17e);
        rd(32'h8, d, r);
        chk(d[22:0], 32'h7e0126);
        rd(32'hc, d, r);
        chk(r, 32'h2);
        wr(32'h4, 32'hff, r);
        chk(r, 32'h0);
    endtask : t_power_up

    task automatic t_nibble_edit;
        logic [31:0] d;
        logic [1:0] r;
        press(3'h4, 8'h02);
        duty(0, 8);
        duty(3, 8);
        chk(lamp_o[2:1], 32'h0);
        press(3'h4, 8'h02);
        duty(0, 4);
        duty(1, 12);
        press(3'h1, 8'h02);
        rd(32'h4, d, r);
        chk(d[31:24], 32'h08);
        press(3'h4, 8'h02);
        chk(lamp_o, 32'h0e);
        press(3'h1, 8'h02);
        rd(32'h4, d, r);
        chk(d[14:8], 32'h7f);
        press(3'h2, 8'h02);
        rd(32'h4, d, r);
        chk({d[14:8], 1'b0, d[6:0]}, 32'h6f7e);
        press(3'h3, 8'h02);
        chk(bus_addr_o, 32'h6f);
        chk({stores, nvm_data_o}, 32'h16f);
    endtask : t_nibble_edit

    task automatic t_whole_entry;
        logic [31:0] d;
        logic [1:0] r;
        wr(32'h0, 32'h2, r);
        press(3'h4, 8'h02);
        press(3'h4, 8'h02);
        chk(lamp_o[0], 32'h1);
        // Held long enough to reach the floor only through auto-repeat
        press(3'h2, 8'd200);
        rd(32'h4, d, r);
        chk({d[31:24], 1'b0, d[14:8]}, 32'h4000);
        press(3'h1, 8'h02);
        rd(32'h4, d, r);
        chk(d[14:8], 32'h1);
        // Held 40 cycles: one press, six unit repeats, then two repeats of 8
        press(3'h1, 8'd40);
        rd(32'h4, d, r);
        chk(d[14:8], 32'h18);
        press(3'h3, 8'h02);
        chk(bus_addr_o, 32'h18);
    endtask : t_whole_entry

    task automatic t_simulation;
        logic [31:0] d;
        logic [1:0] r;
        pos_meas_i <= 16'h1234;
        sim_val_i <= 16'habcd;
        wr(32'h0, 32'h5, r);
        rd(32'h0, d, r);
        chk(d[2:0], 32'h5);
        chk(pos_ret_o, 32'h1234);
        press(3'h4, 8'h02);
        chk(lamp_o, 32'h02);
        press(3'h1, 8'h02);
        chk({lamp_o, pos_ret_o}, 32'h101234);
        press(3'h3, 8'h02);
        chk(pos_ret_o, 32'habcd);
        wr(32'h0, 32'h1, r);
        repeat (2) @(posedge mclk_i);
        chk(pos_ret_o, 32'h1234);
    endtask : t_simulation

    // Mid-run reset with a valid stored configuration, then a lower-nibble edit abandoned
    task automatic t_restore;
        logic [31:0] d;
        logic [1:0] r;
        nvm_valid <= 1'b1;
        nvm_data <= 8'h95;
        arst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk(nvm_data_o, 32'h95);
        rd(32'h4, d, r);
        chk({d[16], 1'b0, d[6:0]}, 32'h115);
        chk(pos_ret_o, 32'h1234);
        // Strobe without byte 0 must leave the control bits alone
        ws <= 4'he;
        wr(32'h0, 32'h7, r);
        ws <= 4'hf;
        rd(32'h0, d, r);
        chk(d[2:0], 32'h0);
        press(3'h4, 8'h02);
        press(3'h4, 8'h02);
        press(3'h4, 8'h02);
        chk(lamp_o, 32'h0a);
        press(3'h1, 8'h02);
        rd(32'h4, d, r);
        chk(d[14:8], 32'h16);
        press(3'h4, 8'h02);
        chk(bus_addr_o, 32'h15);
    endtask : t_restore

    initial begin
        repeat (3) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        t_power_up();
        t_nibble_edit();
        t_whole_entry();
        t_simulation();
        t_restore();
        wrap_up();
    end
endmodule : bake_test
